// ==== rtl/lpc_clk_prescaler.sv ====
/*
 Glitch-free prescaler producing a one-cycle clock enable at sys_clk/2^sel.
 Assumes sel may change at any cycle; it is taken only at a period boundary.
*/
`timescale 1ns/1ns
module lpc_clk_prescaler (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [2:0] div_sel,
    output logic tick
);
    typedef struct packed {
        logic [6:0] cnt;
        logic [2:0] sel;
    } lpc_pre_t;

    lpc_pre_t q, d;
    logic [6:0] last;

    always_comb begin
        d = q;
        last = 7'((8'h01 << q.sel) - 8'h01);
        tick = (q.cnt == last);
        if (tick) begin
            // New ratio only at wrap: no runt or short phase
            d.cnt = 7'h00;
            d.sel = div_sel;
        end else begin
            d.cnt = 7'(q.cnt + 7'h01);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ==== rtl/lpc_pkg.sv ====
/*
 Shared constants and types for the low-power clock and wake controller.
 Assumes a single 125 MHz system clock and an active-high asynchronous reset.
*/
package lpc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int NPERIPH = 8;

    // Sleep mode encodings
    typedef enum logic [2:0] {
        SM_IDLE = 3'h1,
        SM_PDOWN = 3'h2,
        SM_PSAVE = 3'h3,
        SM_STDBY = 3'h6,
        SM_ESTDBY = 3'h7
    } lpc_sleep_t;

    // System clock source
    typedef enum logic [1:0] {
        SRC_RC = 2'h0,
        SRC_EXT = 2'h1,
        SRC_XTAL = 2'h2
    } lpc_clk_src_t;

    // Real-time clock source
    typedef enum logic [1:0] {
        RTC_XTAL = 2'h0,
        RTC_RC = 2'h1,
        RTC_ULP = 2'h2
    } lpc_rtc_src_t;

    // Supply-droop detector operating modes
    typedef enum logic [1:0] {
        DROOP_OFF = 2'h0,
        DROOP_CONT = 2'h1,
        DROOP_SAMPLED = 2'h2
    } lpc_droop_t;

    // Controller states, Gray coded from ST_SLEEP through ST_OSC_WAIT and ST_STARTUP to ST_ISR_LAT
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'h0,
        ST_SLEEP = 3'h1,
        ST_OSC_WAIT = 3'h3,
        ST_STARTUP = 3'h2,
        ST_ISR_LAT = 3'h6
    } lpc_state_t;

    // Timing counts in system clock cycles; EE_WRITE_US in microseconds
    localparam logic [15:0] RC_STARTUP_CYC = 16'h0006;
    localparam logic [15:0] ISR_LAT_CYC = 16'h000D;
    localparam logic [15:0] NVM_REACT_CYC = 16'h000D;
    localparam logic [15:0] XTAL_CERAMIC_CYC = 16'h03E8;
    localparam logic [15:0] XTAL_QUARTZ_CYC = 16'h3E80;
    localparam int EE_WRITE_US = 4;
    localparam logic [15:0] EE_WRITE_CYC = 16'(EE_WRITE_US * CLK_MHZ);
    // 32 kHz to 1 kHz
    localparam logic [4:0] LF_DIV_LAST = 5'h1F;

    // Synchronised pin indices
    localparam int PIN_OSC_RDY = 0;
    localparam int PIN_PORT_IRQ = 1;
    localparam int PIN_TWI = 2;
    localparam int PIN_XTAL32 = 3;
    localparam int PIN_RC32 = 4;
    localparam int PIN_ULP = 5;
    localparam int NPIN = 6;

    // Wake sources
    typedef struct packed {
        logic port;
        logic twi;
        logic rtc;
        logic other;
    } lpc_wake_t;

    // Fuse settings
    typedef struct packed {
        lpc_droop_t droop_active;
        lpc_droop_t droop_sleep;
        logic on_chip_debug_feature;
        logic jtag_fuse_dis;
    } lpc_fuse_t;

    // Nonvolatile memory controller request from the CPU
    typedef struct packed {
        logic pr_en;
        logic access;
        logic target_ee;
    } lpc_nvm_req_t;
endpackage

// ==== rtl/lpc_power_ctrl.sv ====
/*
 Low-power clock and wake controller: prescaling, sleep and wake sequencing,
 peripheral clock gating, RTC, watchdog and droop clocking, debug port
 clocks, nonvolatile memory power-down and EEPROM write timing.
 Assumes CPU and peripherals on sys_clk; oscillator and wake pins are
 asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
module lpc_power_ctrl (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [2:0] prescale_sel,
    input wire logic sleep_req,
    input wire lpc_pkg::lpc_sleep_t sleep_mode,
    input wire lpc_pkg::lpc_clk_src_t clk_src,
    input wire logic [15:0] xtal_startup_cycles,
    input wire logic osc_ready,
    input wire logic async_port_irq,
    input wire logic twi_addr_match,
    input wire logic rtc_irq,
    input wire logic other_irq,
    input wire logic [lpc_pkg::NPERIPH-1:0] peripheral_clock_gate_bits,
    input wire lpc_pkg::lpc_rtc_src_t rtc_src_sel,
    input wire logic rtc_1k_sel,
    input wire logic crystal_low_power_select,
    input wire logic battery_rtc_variant,
    input wire logic low_freq_crystal_osc,
    input wire logic internal_rc_32k_osc,
    input wire logic ultra_low_power_osc,
    input wire logic wdt_enable,
    input wire lpc_pkg::lpc_fuse_t fuses,
    input wire logic jtag_sw_disable,
    input wire logic pdi_enable,
    input wire lpc_pkg::lpc_nvm_req_t nvm_req,
    input wire logic ee_write_start,
    output logic cpu_clk_en,
    output logic cpu_run,
    output logic [lpc_pkg::NPERIPH-1:0] periph_clk_en,
    output logic sysclk_src_run,
    output logic isr_start,
    output lpc_pkg::lpc_wake_t wake_pending,
    output logic rtc_clk_en,
    output logic xtal32_run,
    output logic rc32_run,
    output logic ulp_run,
    output logic xtal_lp_en,
    output logic wdt_tick,
    output logic droop_enable,
    output logic droop_sample,
    output logic jtag_clk_en,
    output logic pdi_clk_en,
    output logic flash_pd,
    output logic eeprom_pd,
    output logic cpu_stall,
    output logic ee_busy
);
    typedef struct packed {
        logic [lpc_pkg::NPIN-1:0] s1;
        logic [lpc_pkg::NPIN-1:0] s2;
        logic [lpc_pkg::NPIN-1:0] s3;
        lpc_pkg::lpc_state_t st;
        lpc_pkg::lpc_sleep_t mode;
        logic [15:0] cnt;
        lpc_pkg::lpc_wake_t pend;
        logic isr_go;
        logic [4:0] rtc_div;
        logic [4:0] ulp_div;
        logic rtc_tick;
        logic ulp_1k;
        logic jtag_sw_dis;
        logic nvm_stall;
        logic [15:0] nvm_cnt;
        logic [1:0] nvm_awake;
        logic [15:0] ee_cnt;
        logic ee_busy;
        logic droop_sample;
    } lpc_regs_t;

    lpc_regs_t q, d;
    logic pre_tick;
    logic periph_on;
    logic rtc_on;
    logic asleep;
    logic wake;
    logic [lpc_pkg::NPIN-1:0] rise;
    logic rtc_edge;
    lpc_pkg::lpc_wake_t w_now;
    lpc_pkg::lpc_droop_t droop_cfg;
    logic [15:0] xtal_dly;
    lpc_pkg::lpc_wake_t awake_mask;

    // Wake sources allowed in a given sleep mode
    function automatic lpc_pkg::lpc_wake_t wake_mask(input lpc_pkg::lpc_sleep_t m,
                                                     input logic bat);
        lpc_pkg::lpc_wake_t r;
        r.port = 1'b1;
        r.twi = 1'b1;
        r.rtc = bat || (m == lpc_pkg::SM_IDLE) || (m == lpc_pkg::SM_PSAVE)
                || (m == lpc_pkg::SM_ESTDBY);
        r.other = (m == lpc_pkg::SM_IDLE);
        return r;
    endfunction

    // Sleep modes that stop the system clock source
    function automatic logic src_stops(input lpc_pkg::lpc_sleep_t m);
        return (m == lpc_pkg::SM_PDOWN) || (m == lpc_pkg::SM_PSAVE);
    endfunction

    lpc_clk_prescaler u_pre (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .div_sel(prescale_sel),
        .tick(pre_tick)
    );

    // Peripheral clock gating per module
    genvar gi;
    generate
        for (gi = 0; gi < lpc_pkg::NPERIPH; gi++) begin : g_gate
            assign periph_clk_en[gi] = pre_tick && periph_on
                                       && !peripheral_clock_gate_bits[gi];
        end
    endgenerate

    always_comb begin
        d = q;
        d.isr_go = 1'b0;
        d.rtc_tick = 1'b0;
        d.ulp_1k = 1'b0;
        d.droop_sample = 1'b0;

        // Synchronisers; s3 only feeds edge detection
        d.s1 = {ultra_low_power_osc, internal_rc_32k_osc, low_freq_crystal_osc,
                twi_addr_match, async_port_irq, osc_ready};
        d.s2 = q.s1;
        d.s3 = q.s2;
        rise = q.s2 & ~q.s3;

        asleep = (q.st == lpc_pkg::ST_SLEEP);
        periph_on = !(asleep && (q.mode != lpc_pkg::SM_IDLE))
                    && (q.st != lpc_pkg::ST_OSC_WAIT)
                    && (q.st != lpc_pkg::ST_STARTUP);
        sysclk_src_run = !(asleep && src_stops(q.mode))
                         && (q.st != lpc_pkg::ST_OSC_WAIT);
        awake_mask = wake_mask(q.mode, 1'b0);
        rtc_on = battery_rtc_variant || !asleep
                 || awake_mask.rtc;

        // Wake sources, latched until the ISR is entered
        w_now.port = q.s2[lpc_pkg::PIN_PORT_IRQ];
        w_now.twi = q.s2[lpc_pkg::PIN_TWI];
        w_now.rtc = rtc_irq;
        w_now.other = other_irq;
        d.pend = (q.isr_go ? '0 : q.pend) | w_now;
        wake = asleep && ((q.pend & wake_mask(q.mode, battery_rtc_variant)) != '0);

        xtal_dly = (xtal_startup_cycles == 16'h0000) ? 16'h0001 : xtal_startup_cycles;

        case (q.st)
            lpc_pkg::ST_ACTIVE: begin
                if (sleep_req) begin
                    d.st = lpc_pkg::ST_SLEEP;
                    d.mode = sleep_mode;
                end
            end
            lpc_pkg::ST_SLEEP: begin
                if (wake) begin
                    if (src_stops(q.mode)) begin
                        d.st = lpc_pkg::ST_OSC_WAIT;
                    end else begin
                        d.st = lpc_pkg::ST_ISR_LAT;
                        d.cnt = 16'(lpc_pkg::ISR_LAT_CYC - 16'h0001);
                    end
                end
            end
            lpc_pkg::ST_OSC_WAIT: begin
                if (q.s2[lpc_pkg::PIN_OSC_RDY]) begin
                    d.st = lpc_pkg::ST_STARTUP;
                    if (clk_src == lpc_pkg::SRC_XTAL) begin
                        d.cnt = 16'(xtal_dly - 16'h0001);
                    end else begin
                        d.cnt = 16'(lpc_pkg::RC_STARTUP_CYC - 16'h0001);
                    end
                end
            end
            lpc_pkg::ST_STARTUP: begin
                if (q.cnt == 16'h0000) begin
                    d.st = lpc_pkg::ST_ISR_LAT;
                    d.cnt = 16'(lpc_pkg::ISR_LAT_CYC - 16'h0001);
                end else begin
                    d.cnt = 16'(q.cnt - 16'h0001);
                end
            end
            lpc_pkg::ST_ISR_LAT: begin
                if (q.cnt == 16'h0000) begin
                    d.st = lpc_pkg::ST_ACTIVE;
                    d.isr_go = 1'b1;
                end else begin
                    d.cnt = 16'(q.cnt - 16'h0001);
                end
            end
            default: begin
                d.st = lpc_pkg::ST_ACTIVE;
            end
        endcase

        // RTC source and 1 kHz prescale
        if (battery_rtc_variant) begin
            rtc_edge = rise[lpc_pkg::PIN_XTAL32];
        end else begin
            case (rtc_src_sel)
                lpc_pkg::RTC_XTAL: rtc_edge = rise[lpc_pkg::PIN_XTAL32];
                lpc_pkg::RTC_RC: rtc_edge = rise[lpc_pkg::PIN_RC32];
                lpc_pkg::RTC_ULP: rtc_edge = rise[lpc_pkg::PIN_ULP];
                default: rtc_edge = 1'b0;
            endcase
        end
        if (rtc_on && rtc_edge) begin
            if (rtc_1k_sel) begin
                d.rtc_div = 5'(q.rtc_div + 5'h01);
                d.rtc_tick = (q.rtc_div == lpc_pkg::LF_DIV_LAST);
            end else begin
                d.rtc_tick = 1'b1;
            end
        end

        // ULTRA_LOW_POWER_OSC prescaled to 1 kHz for watchdog and droop sampling
        if (rise[lpc_pkg::PIN_ULP]) begin
            d.ulp_div = 5'(q.ulp_div + 5'h01);
            d.ulp_1k = (q.ulp_div == lpc_pkg::LF_DIV_LAST);
        end

        // Droop detector configuration by activity
        if (q.st == lpc_pkg::ST_ACTIVE || (asleep && q.mode == lpc_pkg::SM_IDLE)) begin
            droop_cfg = fuses.droop_active;
        end else begin
            droop_cfg = fuses.droop_sleep;
        end
        d.droop_sample = q.ulp_1k && (droop_cfg == lpc_pkg::DROOP_SAMPLED);

        // Software disable of scan port, cleared only by reset
        if (jtag_sw_disable) begin
            d.jtag_sw_dis = 1'b1;
        end

        // Powered-down memory access stalls the CPU
        if (q.nvm_stall) begin
            if (q.nvm_cnt == 16'h0000) begin
                d.nvm_stall = 1'b0;
                d.nvm_awake[nvm_req.target_ee] = 1'b1;
            end else begin
                d.nvm_cnt = 16'(q.nvm_cnt - 16'h0001);
            end
        end else if (nvm_req.access && nvm_req.pr_en
                     && !q.nvm_awake[nvm_req.target_ee]) begin
            d.nvm_stall = 1'b1;
            d.nvm_cnt = 16'(lpc_pkg::NVM_REACT_CYC - 16'h0001);
        end else if (!nvm_req.access || asleep) begin
            d.nvm_awake = 2'h0;
        end

        // EEPROM write: one length for byte or page
        if (q.ee_busy) begin
            if (q.ee_cnt == 16'h0000) begin
                d.ee_busy = 1'b0;
            end else begin
                d.ee_cnt = 16'(q.ee_cnt - 16'h0001);
            end
        end else if (ee_write_start) begin
            d.ee_busy = 1'b1;
            d.ee_cnt = 16'(lpc_pkg::EE_WRITE_CYC - 16'h0001);
        end
    end

    // Clock enables and status
    assign cpu_run = (q.st == lpc_pkg::ST_ACTIVE) && !q.nvm_stall;
    assign cpu_clk_en = pre_tick && cpu_run;
    assign cpu_stall = q.nvm_stall;
    assign isr_start = q.isr_go;
    assign wake_pending = q.pend;
    assign rtc_clk_en = q.rtc_tick;
    assign xtal32_run = rtc_on && (battery_rtc_variant
                        || rtc_src_sel == lpc_pkg::RTC_XTAL);
    assign rc32_run = rtc_on && !battery_rtc_variant
                      && (rtc_src_sel == lpc_pkg::RTC_RC);
    assign ulp_run = wdt_enable || (fuses.droop_active == lpc_pkg::DROOP_SAMPLED)
                     || (fuses.droop_sleep == lpc_pkg::DROOP_SAMPLED)
                     || (rtc_on && rtc_src_sel == lpc_pkg::RTC_ULP);
    assign xtal_lp_en = xtal32_run && crystal_low_power_select;
    assign wdt_tick = q.ulp_1k && wdt_enable;
    assign droop_enable = (droop_cfg != lpc_pkg::DROOP_OFF);
    assign droop_sample = q.droop_sample;
    assign jtag_clk_en = !fuses.jtag_fuse_dis && !q.jtag_sw_dis
                         && (q.st == lpc_pkg::ST_ACTIVE
                             || fuses.on_chip_debug_feature);
    assign pdi_clk_en = pdi_enable;
    assign flash_pd = asleep || (nvm_req.pr_en && !q.nvm_awake[0]);
    assign eeprom_pd = (asleep || (nvm_req.pr_en && !q.nvm_awake[1]))
                       && !q.ee_busy;
    assign ee_busy = q.ee_busy;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.mode <= lpc_pkg::SM_IDLE;
        end else begin
            q <= d;
        end
    end
endmodule

// ==== tb/lpc_cpu_model.sv ====
/* CPU-side model issuing nonvolatile memory accesses.
 Assumes go pulses arrive just after sys_clk rising edges. */
`timescale 1ns/1ns
module lpc_cpu_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic nvm_go,
    input wire logic go_ee,
    input wire logic cpu_stall,
    output lpc_pkg::lpc_nvm_req_t nvm_req,
    output logic [15:0] stall_cycles
);
    logic seen_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nvm_req <= '{pr_en: 1'b1, access: 1'b0, target_ee: 1'b0};
            seen_q <= 1'b0;
            stall_cycles <= 16'h0000;
        end else if (nvm_go && !nvm_req.access) begin
            nvm_req.access <= 1'b1;
            nvm_req.target_ee <= go_ee;
            seen_q <= 1'b0;
            stall_cycles <= 16'h0000;
        end else if (cpu_stall) begin
            seen_q <= 1'b1;
            stall_cycles <= stall_cycles + 16'h0001;
        end else if (seen_q && nvm_req.access) begin
            // Access held one cycle past the stall
            nvm_req.access <= 1'b0;
        end
    end
endmodule

// ==== tb/lpc_power_ctrl_sva.sv ====
/* Port checker for lpc_power_ctrl.
 Assumes one sys_clk domain; bound to every instance of the controller. */
`timescale 1ns/1ns
module lpc_power_ctrl_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [lpc_pkg::NPERIPH-1:0] peripheral_clock_gate_bits,
    input wire logic wdt_enable,
    input wire lpc_pkg::lpc_fuse_t fuses,
    input wire logic jtag_sw_disable,
    input wire logic pdi_enable,
    input wire logic cpu_clk_en,
    input wire logic cpu_run,
    input wire logic [lpc_pkg::NPERIPH-1:0] periph_clk_en,
    input wire logic sysclk_src_run,
    input wire logic isr_start,
    input wire logic wdt_tick,
    input wire logic jtag_clk_en,
    input wire logic pdi_clk_en,
    input wire logic eeprom_pd,
    input wire logic cpu_stall,
    input wire logic ee_busy
);
    logic [15:0] ee_cnt_q;
    logic [15:0] ee_cnt_d;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Cycles the write has been busy
    always_comb ee_cnt_d = ee_busy ? ee_cnt_q + 16'h0001 : 16'h0000;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ee_cnt_q <= 16'h0000;
        end else begin
            ee_cnt_q <= ee_cnt_d;
        end
    end
    sequence s_stall_13;
        cpu_stall [*8] ##1 cpu_stall [*5] ##1 !cpu_stall;
    endsequence
    property p_isr_lat;
        isr_start |-> !$past(cpu_run) && !$past(cpu_run, 13);
    endproperty
    a_isr_lat: assert property (p_isr_lat) else $error("isr start too soon");
    property p_run_clk;
        cpu_clk_en |-> cpu_run;
    endproperty
    a_run_clk: assert property (p_run_clk) else $error("cpu clocked while held");
    property p_gate;
        (periph_clk_en & peripheral_clock_gate_bits) == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("gated module clocked");
    property p_deep;
        !sysclk_src_run && !cpu_run |-> periph_clk_en == '0;
    endproperty
    a_deep: assert property (p_deep) else $error("peripheral clock in deep sleep");
    property p_ee_time;
        $fell(ee_busy) |-> ee_cnt_q == lpc_pkg::EE_WRITE_CYC;
    endproperty
    a_ee_time: assert property (p_ee_time) else $error("write time wrong");
    property p_ee_pd;
        ee_busy |-> !eeprom_pd;
    endproperty
    a_ee_pd: assert property (p_ee_pd) else $error("eeprom off while writing");
    property p_stall;
        $rose(cpu_stall) |-> s_stall_13;
    endproperty
    a_stall: assert property (p_stall) else $error("stall length wrong");
    property p_stall_halt;
        cpu_stall |-> !cpu_run;
    endproperty
    a_stall_halt: assert property (p_stall_halt) else $error("cpu runs in stall");
    property p_jtag;
        jtag_sw_disable || fuses.jtag_fuse_dis |=> !jtag_clk_en;
    endproperty
    a_jtag: assert property (p_jtag) else $error("scan port still clocked");
    property p_pdi;
        pdi_enable |-> pdi_clk_en;
    endproperty
    a_pdi: assert property (p_pdi) else $error("debug port clock off");
    property p_wdt;
        !wdt_enable |-> !wdt_tick;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog ticks disabled");
endmodule
bind lpc_power_ctrl lpc_power_ctrl_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .peripheral_clock_gate_bits(peripheral_clock_gate_bits), .wdt_enable(wdt_enable),
    .fuses(fuses), .jtag_sw_disable(jtag_sw_disable), .pdi_enable(pdi_enable),
    .cpu_clk_en(cpu_clk_en), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
    .sysclk_src_run(sysclk_src_run), .isr_start(isr_start), .wdt_tick(wdt_tick),
    .jtag_clk_en(jtag_clk_en), .pdi_clk_en(pdi_clk_en), .eeprom_pd(eeprom_pd),
    .cpu_stall(cpu_stall), .ee_busy(ee_busy));

// ==== tb/tb_lpc_power_ctrl.sv ====
/* Testbench for lpc_power_ctrl: table of sleep and wake cases, then
 start-up, stall, EEPROM, gating and scan port cases.
 Assumes package, design, checker and CPU model compiled first. */
`timescale 1ns/1ns
module tb_lpc_power_ctrl;
    typedef struct packed {
        lpc_pkg::lpc_sleep_t mode;
        logic [1:0] src;
        logic wake;
        logic src_run;
    } lpc_row_t;
    localparam lpc_row_t ROWS [8] = '{
        '{lpc_pkg::SM_IDLE, 2'h0, 1'b1, 1'b1}, '{lpc_pkg::SM_IDLE, 2'h1, 1'b1, 1'b1},
        '{lpc_pkg::SM_PSAVE, 2'h1, 1'b1, 1'b0}, '{lpc_pkg::SM_PDOWN, 2'h1, 1'b0, 1'b0},
        '{lpc_pkg::SM_PDOWN, 2'h3, 1'b1, 1'b0}, '{lpc_pkg::SM_STDBY, 2'h2, 1'b1, 1'b1},
        '{lpc_pkg::SM_ESTDBY, 2'h1, 1'b1, 1'b1}, '{lpc_pkg::SM_STDBY, 2'h0, 1'b0, 1'b1}};
    logic sys_clk = 1'b0, sys_rst = 1'b1, sleep_req = 1'b0, osc32 = 1'b0, nvm_go = 1'b0;
    logic osc_ready = 1'b1, wdt_enable = 1'b0, jtag_sw_disable = 1'b0, pdi_enable = 1'b1;
    logic ee_write_start = 1'b0;
    logic [2:0] prescale_sel = 3'h0;
    logic [3:0] wk = 4'h0;
    logic [7:0] gate = 8'h00;
    logic [7:0] periph_clk_en;
    logic [15:0] xtal_startup_cycles = 16'h0028;
    logic [15:0] stall_cycles;
    lpc_pkg::lpc_sleep_t sleep_mode = lpc_pkg::SM_IDLE;
    lpc_pkg::lpc_clk_src_t clk_src = lpc_pkg::SRC_RC;
    lpc_pkg::lpc_fuse_t fuses = '{lpc_pkg::DROOP_CONT, lpc_pkg::DROOP_OFF, 1'b0, 1'b0};
    lpc_pkg::lpc_nvm_req_t nvm_req;
    lpc_pkg::lpc_wake_t wake_pending;
    logic cpu_clk_en, cpu_run, sysclk_src_run, isr_start, jtag_clk_en, pdi_clk_en;
    logic eeprom_pd, cpu_stall, ee_busy, wdt_tick;
    logic rtc_clk_en, droop_enable, flash_pd;
    int num_errors = 0, check_count = 0, cyc = 0;
    lpc_power_ctrl dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .prescale_sel(prescale_sel),
        .sleep_req(sleep_req), .sleep_mode(sleep_mode), .clk_src(clk_src),
        .xtal_startup_cycles(xtal_startup_cycles), .osc_ready(osc_ready),
        .async_port_irq(wk[3]), .twi_addr_match(wk[2]), .rtc_irq(wk[1]), .other_irq(wk[0]),
        .peripheral_clock_gate_bits(gate), .rtc_src_sel(lpc_pkg::RTC_ULP), .rtc_1k_sel(1'b1),
        .crystal_low_power_select(1'b1), .battery_rtc_variant(1'b0),
        .low_freq_crystal_osc(osc32), .internal_rc_32k_osc(osc32), .ultra_low_power_osc(osc32),
        .wdt_enable(wdt_enable), .fuses(fuses), .jtag_sw_disable(jtag_sw_disable),
        .pdi_enable(pdi_enable), .nvm_req(nvm_req), .ee_write_start(ee_write_start),
        .cpu_clk_en(cpu_clk_en), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
        .sysclk_src_run(sysclk_src_run), .isr_start(isr_start), .wake_pending(wake_pending),
        .rtc_clk_en(rtc_clk_en), .xtal32_run(), .rc32_run(), .ulp_run(), .xtal_lp_en(),
        .wdt_tick(wdt_tick), .droop_enable(droop_enable), .droop_sample(),
        .jtag_clk_en(jtag_clk_en), .pdi_clk_en(pdi_clk_en), .flash_pd(flash_pd),
        .eeprom_pd(eeprom_pd), .cpu_stall(cpu_stall),
        .ee_busy(ee_busy));
    lpc_cpu_model cpu_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .nvm_go(nvm_go), .go_ee(1'b1),
        .cpu_stall(cpu_stall), .nvm_req(nvm_req), .stall_cycles(stall_cycles));
    initial forever #4 sys_clk = ~sys_clk;
    initial forever #100 osc32 = ~osc32;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic do_reset();
        sys_rst = 1'b1;
        step(4);
        sys_rst = 1'b0;
    endtask
    task automatic go_sleep(input lpc_pkg::lpc_sleep_t m);
        sleep_mode = m;
        sleep_req = 1'b1;
        step(1);
        sleep_req = 1'b0;
        step(2);
    endtask
    task automatic wake(input int s, input int lim, output int lat);
        wk[s] = 1'b1;
        lat = -1;
        for (int i = 1; i <= lim && lat < 0; i++) begin
            step(1);
            if (i == 3) wk[s] = 1'b0;
            if (isr_start === 1'b1) lat = i;
        end
        wk[s] = 1'b0;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        int lat, lat_rc, n_cpu, n_p0, n_p1, n_rtc, n_wdt;
        foreach (ROWS[i]) begin
            do_reset();
            go_sleep(ROWS[i].mode);
            check(cpu_run, 1'b0);
            check(sysclk_src_run, ROWS[i].src_run);
            check(flash_pd, 1'b1);
            check(droop_enable, ROWS[i].mode == lpc_pkg::SM_IDLE);
            wake(ROWS[i].src, 80, lat);
            check(lat > 0, ROWS[i].wake);
            if (lat > 0) check(lat >= 14, 1'b1);
            if (i == 4) lat_rc = lat;
        end
        do_reset();
        clk_src = lpc_pkg::SRC_XTAL;
        go_sleep(lpc_pkg::SM_PDOWN);
        wk = 4'h8;
        step(3);
        wk = 4'h0;
        step(10);
        wk = 4'h4;
        step(3);
        wk = 4'h0;
        for (lat = 16; isr_start !== 1'b1 && lat < 150; lat++) step(1);
        check(16'(lat - lat_rc), 16'h0022);
        check(wake_pending, 4'hC);
        do_reset();
        check(jtag_clk_en, 1'b1);
        check(eeprom_pd, 1'b1);
        nvm_go = 1'b1;
        step(1);
        nvm_go = 1'b0;
        for (int i = 0; i < 40 && (cpu_stall === 1'b1 || stall_cycles == 0); i++) step(1);
        check(stall_cycles, lpc_pkg::NVM_REACT_CYC);
        check(eeprom_pd, 1'b0);
        step(2);
        ee_write_start = 1'b1;
        step(1);
        ee_write_start = 1'b0;
        step(100);
        ee_write_start = 1'b1;
        step(1);
        ee_write_start = 1'b0;
        for (lat = 101; ee_busy === 1'b1 && lat < 700; lat++) step(1);
        check(16'(lat), lpc_pkg::EE_WRITE_CYC);
        // Gate bit set for module 0 only; CPU and module 1 keep their sys_clk/8 enable
        gate = 8'h01;
        prescale_sel = 3'h3;
        step(20);
        n_cpu = 0;
        n_p0 = 0;
        n_p1 = 0;
        repeat (64) begin
            step(1);
            n_cpu += int'(cpu_clk_en === 1'b1);
            n_p0 += int'(periph_clk_en[0] === 1'b1);
            n_p1 += int'(periph_clk_en[1] === 1'b1);
        end
        check(16'(n_cpu), 16'h0008);
        check(16'(n_p1), 16'h0008);
        check(16'(n_p0), 16'h0000);
        gate = 8'h00;
        jtag_sw_disable = 1'b1;
        step(2);
        jtag_sw_disable = 1'b0;
        step(2);
        check(jtag_clk_en, 1'b0);
        do_reset();
        check(jtag_clk_en, 1'b1);
        check(droop_enable, 1'b1);
        // Two full 1 kHz periods of the slow oscillator
        wdt_enable = 1'b1;
        step(2);
        n_rtc = 0;
        n_wdt = 0;
        repeat (1600) begin
            step(1);
            n_rtc += int'(rtc_clk_en === 1'b1);
            n_wdt += int'(wdt_tick === 1'b1);
        end
        check(16'(n_rtc), 16'h0002);
        check(16'(n_wdt), 16'h0002);
        complete_run();
    end
endmodule
